// file: design/iaec_pkg.sv
`default_nettype none
package iaec_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_PERIPH_MASK = 8'h0e;
  localparam logic [7:0] ADDR_SOURCE_MASK = 8'h0f;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_CONV_STATUS = 8'h11;
  localparam logic [7:0] ADDR_CONV_CTRL = 8'h12;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h13;
  localparam logic [7:0] ADDR_CONTROL = 8'h14;
  localparam logic [7:0] ADDR_RESULT_LO = 8'h15;
  localparam logic [7:0] ADDR_RESULT_HI = 8'h16;
  localparam logic [7:0] ADDR_STATUS_REG = 8'h17;
  localparam logic [7:0] ADDR_REG_SELECT = 8'h18;
  // Peripheral mask / converter status bit positions
  localparam int PM_PULSE1 = 4;
  localparam int PM_CONV_DONE = 5;
  localparam int PM_SERIAL_RX = 6;
  localparam int PM_PULSE2 = 7;
  localparam logic [7:0] PM_VALID = 8'hf0;
  // Source mask / irq status bit positions
  localparam int SM_TIMER = 0;
  localparam int SM_FIRST_COUNTER_IRQ_ENABLE = 1;
  localparam int SM_SECOND_COUNTER_IRQ_ENABLE = 2;
  localparam int SM_PIN_A = 3;
  localparam int SM_PIN_B = 4;
  localparam int SM_PIN_C = 5;
  localparam int SM_PIN_D = 7;
  localparam logic [7:0] SM_VALID = 8'hbf;
  // Converter control fields
  localparam int CC_START = 0;
  localparam int CC_POWER = 2;
  localparam int CC_CLKSEL_LO = 3;
  localparam int CC_CHAN_LO = 5;
  localparam logic [7:0] CC_VALID = 8'hfd;
  // Mode control and control register fields
  localparam int MC_NORMAL = 6;
  localparam int MC_NO_SLEEP = 7;
  localparam int CT_PIN_A_RISE = 7;
  // Reset values
  localparam logic [7:0] RST_PERIPH_MASK = 8'h00;
  localparam logic [7:0] RST_SOURCE_MASK = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_CONV_CTRL = 8'h00;
  localparam logic [7:0] RST_MODE_CTRL = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'hff;
  localparam logic [7:0] STATUS_POR_KEEP = 8'h1f;
  localparam logic [7:0] REGSEL_POR_KEEP = 8'h3f;
  localparam logic [11:0] VECTOR_ADDR = 12'h008;
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CONV_MIN_NS = 13000;
  localparam int CONV_MIN_CYC = (CONV_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
    / CLK_PERIOD_PS;
  localparam int ADC_CLKS_PER_CONV = 12;
  localparam int ADC_TICK_BASE = (CONV_MIN_CYC + ADC_CLKS_PER_CONV - 1)
    / ADC_CLKS_PER_CONV;
  typedef enum logic [1:0] {
    PWR_RUN = 2'b01,
    PWR_SLEEP = 2'b10
  } iaec_pwr_t;
  typedef enum logic [2:0] {
    ADC_OFF = 3'b001,
    ADC_IDLE = 3'b010,
    ADC_CONV = 3'b100
  } iaec_adc_t;
endpackage : iaec_pkg
`default_nettype wire

// file: design/iaec_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RL1 - Peripheral mask bits 4..7 enable sources
// RL2 - Software starts conversion via start bit
// RL3 - Conversion lasts twelve converter clocks
// RL4 - Ten-bit result split over two registers
// RL5 - Mask set: clear start, raise completion
// RL6 - Done flag sticky until software clears
// RL7 - Mask clear: convert continuously, no flag
// RL8 - Re-enabling mask resumes done flag
// RL9 - Power bit zero powers converter down
// RL10 - Source mask bits enable timer/counters/pins
// RL11 - Software keeps source mask bit 6 zero
// RL12 - Enabled request with global enable vectors 008
// RL13 - Mode bit 6 selects green or normal
// RL14 - No conversion interrupt in green mode
// RL15 - Pin A edge polarity from control bit7
// RL16 - Pins B, C, D falling edge only
// RL17 - Converter source on flag rising edge; code requests on the flag level while it stays set
// RL18 - Enable/disable instructions drive global enable
// RL19 - Requests recorded as status flag bits
// RL20 - Service routine clears flag before return
// RL21 - Reset on power-on, watchdog, reset pin
// RL22 - Reset zeroes PC, clears watchdog, control ones
// RL23 - Power-on clears upper status/select bits
// RL24 - Sleep instruction stops core and oscillator
// RL25 - Wake-up acts as power-on reset
// RL26 - One vector for many requests; software polls
module iaec_top #(
  parameter int ADC_TICK_DIV = iaec_pkg::ADC_TICK_BASE
) (
  input wire logic clk, // 250 MHz clock
  input wire logic srst, // Power-on reset, synchronous
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after strobe
  input wire logic tcc_timeout, // Timer timeout pulse
  input wire logic first_counter_irq_enable_timeout, // First counter timeout pulse
  input wire logic second_counter_irq_enable_timeout, // Second counter timeout pulse
  input wire logic pulse1_event, // First pulse-width channel event
  input wire logic pulse2_event, // Second pulse-width channel event
  input wire logic serial_rx_full, // Serial receive buffer full
  input wire logic [3:0] ext_pin, // External pins a..d, async
  input wire logic ext_reset_pin_n, // External reset pin, async
  input wire logic wdt_enable, // Watchdog enabled
  input wire logic wdt_timeout, // Watchdog timeout pulse
  input wire logic global_irq_on_instr, // Enable-interrupt executed
  input wire logic global_irq_off_instr, // Disable-interrupt executed
  input wire logic sleep_instr, // Sleep instruction executed
  input wire logic [9:0] adc_sample_data, // Converter result bits
  output logic vector_fetch, // Fetch next from vector address
  output logic [11:0] vector_addr, // Fixed vector address
  output logic global_irq_enabled, // Global enable state
  output logic core_reset, // Zero program counter, restart
  output logic wdt_clear, // Clear and disable watchdog
  output logic cpu_stop, // Core halted in sleep
  output logic osc_stop, // Oscillator stopped in sleep
  output logic adc_bias_en, // Converter bias powered
  output logic [2:0] adc_channel, // Converter input channel
  output logic adc_busy // Conversion in progress
);
  import iaec_pkg::*;

  localparam int DIV_W = 15;

  initial begin
    if (ADC_TICK_DIV < 1 || ADC_TICK_DIV * 8 > (1 << DIV_W)) begin
      $error("ADC_TICK_DIV out of range");
    end
  end

  typedef struct packed {
    logic [7:0] periph_mask;
    logic [7:0] source_mask;
    logic [7:0] irq_flags;
    logic [7:0] conv_flags;
    logic [7:0] conv_ctrl;
    logic [7:0] mode_ctrl;
    logic [7:0] control;
    logic [7:0] result_lo;
    logic [1:0] result_hi;
    logic [7:0] status_reg;
    logic [7:0] reg_select;
    logic [7:0] rdata;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] pin_prev;
    logic rst_meta;
    logic rst_sync;
    logic gie;
    logic vector_fetch;
    logic core_reset;
    logic wdt_clear;
    iaec_pwr_t pwr;
    iaec_adc_t adc;
    logic [DIV_W-1:0] div_cnt;
    logic [3:0] step_cnt;
  } iaec_state_t;

  localparam iaec_state_t RST_STATE = '{
    periph_mask: RST_PERIPH_MASK,
    source_mask: RST_SOURCE_MASK,
    irq_flags: RST_FLAGS,
    conv_flags: RST_FLAGS,
    conv_ctrl: RST_CONV_CTRL,
    mode_ctrl: RST_MODE_CTRL,
    control: RST_CONTROL,
    result_lo: 8'h00,
    result_hi: 2'h0,
    status_reg: 8'h00,
    reg_select: 8'h00,
    rdata: 8'h00,
    pin_meta: 4'hf,
    pin_sync: 4'hf,
    pin_prev: 4'hf,
    rst_meta: 1'b1,
    rst_sync: 1'b1,
    gie: 1'b0,
    vector_fetch: 1'b0,
    core_reset: 1'b1,
    wdt_clear: 1'b1,
    pwr: PWR_RUN,
    adc: ADC_OFF,
    div_cnt: '0,
    step_cnt: 4'h0
  };

  localparam logic [3:0] LAST_STEP = 4'(ADC_CLKS_PER_CONV - 1);
  localparam logic [DIV_W-1:0] TICK_BASE = DIV_W'(ADC_TICK_DIV);

  iaec_state_t cur_ff;
  iaec_state_t nxt_st;

  logic [3:0] fall_edge;
  logic [3:0] rise_edge;
  logic [3:0] pin_event;
  logic [7:0] irq_set;
  logic [7:0] conv_set;
  logic [7:0] irq_enabled;
  logic [7:0] periph_enabled;
  logic normal_mode;
  logic irq_pending;
  logic ext_rst;
  logic wdt_rst;
  logic wake;
  logic any_rst;
  logic [DIV_W-1:0] tick_limit;
  logic tick;
  logic conv_done;
  logic wr_periph;
  logic wr_source;
  logic wr_irq;
  logic wr_conv;
  logic wr_cctrl;
  logic wr_mode;
  logic wr_ctrl;
  logic wr_status;
  logic wr_regsel;

  always_comb begin
    nxt_st = cur_ff;
    // Synchronisers: first stage feeds only the second
    nxt_st.pin_meta = ext_pin;
    nxt_st.pin_sync = cur_ff.pin_meta;
    nxt_st.pin_prev = cur_ff.pin_sync;
    nxt_st.rst_meta = ext_reset_pin_n;
    nxt_st.rst_sync = cur_ff.rst_meta;

    fall_edge = cur_ff.pin_prev & ~cur_ff.pin_sync;
    rise_edge = ~cur_ff.pin_prev & cur_ff.pin_sync;
    pin_event[0] = cur_ff.control[CT_PIN_A_RISE] ? rise_edge[0] :
      fall_edge[0]; // RL15
    pin_event[3:1] = fall_edge[3:1]; // RL16

    normal_mode = cur_ff.mode_ctrl[MC_NORMAL]; // RL13

    // Write decode
    wr_periph = 1'b0;
    wr_source = 1'b0;
    wr_irq = 1'b0;
    wr_conv = 1'b0;
    wr_cctrl = 1'b0;
    wr_mode = 1'b0;
    wr_ctrl = 1'b0;
    wr_status = 1'b0;
    wr_regsel = 1'b0;
    if (reg_wr) begin
      if (reg_addr == ADDR_PERIPH_MASK) begin
        wr_periph = 1'b1;
      end else if (reg_addr == ADDR_SOURCE_MASK) begin
        wr_source = 1'b1;
      end else if (reg_addr == ADDR_IRQ_STATUS) begin
        wr_irq = 1'b1;
      end else if (reg_addr == ADDR_CONV_STATUS) begin
        wr_conv = 1'b1;
      end else if (reg_addr == ADDR_CONV_CTRL) begin
        wr_cctrl = 1'b1;
      end else if (reg_addr == ADDR_MODE_CTRL) begin
        wr_mode = 1'b1;
      end else if (reg_addr == ADDR_CONTROL) begin
        wr_ctrl = 1'b1;
      end else if (reg_addr == ADDR_STATUS_REG) begin
        wr_status = 1'b1;
      end else if (reg_addr == ADDR_REG_SELECT) begin
        wr_regsel = 1'b1;
      end
    end

    if (wr_periph) begin
      nxt_st.periph_mask = reg_wdata & PM_VALID; // RL1
    end
    if (wr_source) begin
      // Bit 6 is stored as written; software must keep it zero
      nxt_st.source_mask = reg_wdata; // RL10 RL11
    end
    if (wr_mode) begin
      nxt_st.mode_ctrl = reg_wdata;
    end
    if (wr_ctrl) begin
      nxt_st.control = reg_wdata;
    end
    if (wr_status) begin
      nxt_st.status_reg = reg_wdata;
    end
    if (wr_regsel) begin
      nxt_st.reg_select = reg_wdata;
    end

    // Converter clock: base divider scaled by 1, 2, 4 or 8
    tick_limit = TICK_BASE << cur_ff.conv_ctrl[CC_CLKSEL_LO +: 2];
    tick = (cur_ff.div_cnt == tick_limit - DIV_W'(1));
    conv_done = 1'b0;
    nxt_st.div_cnt = tick ? '0 : cur_ff.div_cnt + DIV_W'(1);
    case (cur_ff.adc)
      ADC_OFF: begin
        nxt_st.div_cnt = '0;
        nxt_st.step_cnt = 4'h0;
        if (cur_ff.conv_ctrl[CC_POWER]) begin // RL9
          nxt_st.adc = ADC_IDLE;
        end
      end
      ADC_IDLE: begin
        nxt_st.div_cnt = '0;
        nxt_st.step_cnt = 4'h0;
        if (!cur_ff.conv_ctrl[CC_POWER]) begin // RL9
          nxt_st.adc = ADC_OFF;
        end else if (cur_ff.conv_ctrl[CC_START]) begin // RL2
          nxt_st.adc = ADC_CONV;
        end
      end
      ADC_CONV: begin
        if (!cur_ff.conv_ctrl[CC_POWER]) begin // RL9
          nxt_st.adc = ADC_OFF;
        end else if (!cur_ff.conv_ctrl[CC_START]) begin
          // Software abort: partial result is dropped
          nxt_st.adc = ADC_IDLE;
        end else if (tick) begin
          if (cur_ff.step_cnt == LAST_STEP) begin // RL3
            conv_done = 1'b1;
            nxt_st.step_cnt = 4'h0;
            if (cur_ff.periph_mask[PM_CONV_DONE]) begin
              nxt_st.adc = ADC_IDLE; // RL5
            end
          end else begin
            nxt_st.step_cnt = cur_ff.step_cnt + 4'h1;
          end
        end
      end
      default: begin
        nxt_st.adc = ADC_OFF;
      end
    endcase
    if (conv_done) begin
      nxt_st.result_lo = adc_sample_data[7:0]; // RL4
      nxt_st.result_hi = adc_sample_data[9:8]; // RL4
    end

    // Start bit: hardware clear first, a software write in the same
    // cycle overrides it so a fresh start is never lost
    if (conv_done && cur_ff.periph_mask[PM_CONV_DONE]) begin
      nxt_st.conv_ctrl[CC_START] = 1'b0; // RL5 RL7
    end
    if (wr_cctrl) begin
      nxt_st.conv_ctrl = reg_wdata & CC_VALID;
    end

    // Sticky flags; write 0 clears, a set in the same cycle wins
    irq_set = 8'h00;
    irq_set[SM_TIMER] = tcc_timeout;
    irq_set[SM_FIRST_COUNTER_IRQ_ENABLE] = first_counter_irq_enable_timeout;
    irq_set[SM_SECOND_COUNTER_IRQ_ENABLE] = second_counter_irq_enable_timeout;
    irq_set[SM_PIN_A] = pin_event[0];
    irq_set[SM_PIN_B] = pin_event[1];
    irq_set[SM_PIN_C] = pin_event[2];
    irq_set[SM_PIN_D] = pin_event[3];
    conv_set = 8'h00;
    conv_set[PM_PULSE1] = pulse1_event;
    conv_set[PM_SERIAL_RX] = serial_rx_full;
    conv_set[PM_PULSE2] = pulse2_event;
    // Done flag only while the mask bit is one; its level is the
    // converter's interrupt source
    conv_set[PM_CONV_DONE] = conv_done &
      cur_ff.periph_mask[PM_CONV_DONE]; // RL6 RL7 RL8 RL17
    nxt_st.irq_flags = (wr_irq ? cur_ff.irq_flags & reg_wdata :
      cur_ff.irq_flags) | irq_set; // RL19 RL20
    nxt_st.conv_flags = (wr_conv ? cur_ff.conv_flags & reg_wdata :
      cur_ff.conv_flags) | conv_set; // RL6 RL19 RL20

    // Vectoring
    irq_enabled = cur_ff.irq_flags & cur_ff.source_mask & SM_VALID;
    periph_enabled = cur_ff.conv_flags & cur_ff.periph_mask;
    periph_enabled[PM_CONV_DONE] = periph_enabled[PM_CONV_DONE] &
      normal_mode; // RL14
    irq_pending = |irq_enabled | |periph_enabled;
    if (global_irq_on_instr) begin
      nxt_st.gie = 1'b1; // RL18
    end else if (global_irq_off_instr) begin
      nxt_st.gie = 1'b0; // RL18
    end
    nxt_st.vector_fetch = 1'b0;
    // Entry drops global enable so one vector serves every pending
    // source; the service routine polls flags and re-enables
    if (irq_pending && cur_ff.gie && !cur_ff.vector_fetch &&
        cur_ff.pwr == PWR_RUN) begin // RL12 RL26
      nxt_st.vector_fetch = 1'b1;
      nxt_st.gie = 1'b0; // RL26
    end

    // Sleep and wake-up
    wake = 1'b0;
    case (cur_ff.pwr)
      PWR_RUN: begin
        if (sleep_instr && !cur_ff.mode_ctrl[MC_NO_SLEEP]) begin
          nxt_st.pwr = PWR_SLEEP; // RL24
          nxt_st.vector_fetch = 1'b0;
        end
      end
      PWR_SLEEP: begin
        wake = (wdt_enable && wdt_timeout) || !cur_ff.rst_sync ||
          |(pin_event & {cur_ff.source_mask[SM_PIN_D],
          cur_ff.source_mask[SM_PIN_C], cur_ff.source_mask[SM_PIN_B],
          cur_ff.source_mask[SM_PIN_A]}); // RL25
      end
      default: begin
        nxt_st.pwr = PWR_RUN;
      end
    endcase

    // Resets
    ext_rst = !cur_ff.rst_sync; // RL21
    wdt_rst = wdt_enable && wdt_timeout; // RL21
    any_rst = ext_rst || wdt_rst || wake;
    nxt_st.core_reset = any_rst; // RL22
    nxt_st.wdt_clear = any_rst; // RL22
    if (any_rst) begin
      nxt_st.periph_mask = RST_PERIPH_MASK;
      nxt_st.source_mask = RST_SOURCE_MASK;
      nxt_st.irq_flags = RST_FLAGS;
      nxt_st.conv_flags = RST_FLAGS;
      nxt_st.conv_ctrl = RST_CONV_CTRL;
      nxt_st.mode_ctrl = RST_MODE_CTRL;
      nxt_st.control = RST_CONTROL; // RL22
      nxt_st.gie = 1'b0;
      nxt_st.vector_fetch = 1'b0;
      nxt_st.pwr = PWR_RUN; // RL25
      nxt_st.adc = ADC_OFF;
      nxt_st.status_reg = cur_ff.status_reg;
      nxt_st.reg_select = cur_ff.reg_select;
    end
    if (wake) begin
      // Wake-up counts as power-on
      nxt_st.status_reg = cur_ff.status_reg & STATUS_POR_KEEP; // RL23 RL25
      nxt_st.reg_select = cur_ff.reg_select & REGSEL_POR_KEEP; // RL23 RL25
    end

    // Read data valid only in the cycle after the strobe
    nxt_st.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ADDR_PERIPH_MASK) begin
        nxt_st.rdata = cur_ff.periph_mask;
      end else if (reg_addr == ADDR_SOURCE_MASK) begin
        nxt_st.rdata = cur_ff.source_mask;
      end else if (reg_addr == ADDR_IRQ_STATUS) begin
        nxt_st.rdata = cur_ff.irq_flags;
      end else if (reg_addr == ADDR_CONV_STATUS) begin
        nxt_st.rdata = cur_ff.conv_flags;
      end else if (reg_addr == ADDR_CONV_CTRL) begin
        nxt_st.rdata = cur_ff.conv_ctrl;
      end else if (reg_addr == ADDR_MODE_CTRL) begin
        nxt_st.rdata = cur_ff.mode_ctrl;
      end else if (reg_addr == ADDR_CONTROL) begin
        nxt_st.rdata = cur_ff.control;
      end else if (reg_addr == ADDR_RESULT_LO) begin
        nxt_st.rdata = cur_ff.result_lo;
      end else if (reg_addr == ADDR_RESULT_HI) begin
        nxt_st.rdata = {6'h00, cur_ff.result_hi};
      end else if (reg_addr == ADDR_STATUS_REG) begin
        nxt_st.rdata = cur_ff.status_reg;
      end else if (reg_addr == ADDR_REG_SELECT) begin
        nxt_st.rdata = cur_ff.reg_select;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur_ff <= RST_STATE; // RL21 RL22 RL23
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign vector_fetch = cur_ff.vector_fetch;
  assign vector_addr = VECTOR_ADDR; // RL12
  assign global_irq_enabled = cur_ff.gie;
  assign core_reset = cur_ff.core_reset;
  assign wdt_clear = cur_ff.wdt_clear;
  assign cpu_stop = (cur_ff.pwr == PWR_SLEEP); // RL24
  assign osc_stop = (cur_ff.pwr == PWR_SLEEP); // RL24
  assign adc_bias_en = cur_ff.conv_ctrl[CC_POWER]; // RL9
  assign adc_channel = cur_ff.conv_ctrl[CC_CHAN_LO +: 3];
  assign adc_busy = (cur_ff.adc == ADC_CONV);
endmodule : iaec_top
`default_nettype wire

// file: testbench/iaec_props.sv
`timescale 1ns/1ps
`default_nettype none
module iaec_props (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic global_irq_on_instr, // Enable instruction
  input wire logic global_irq_off_instr, // Disable instruction
  input wire logic vector_fetch, // Vector pulse
  input wire logic [11:0] vector_addr, // Vector address
  input wire logic global_irq_enabled, // Global enable
  input wire logic core_reset, // Reset pulse
  input wire logic wdt_clear, // Watchdog clear
  input wire logic cpu_stop, // Core halted
  input wire logic osc_stop, // Oscillator halted
  input wire logic adc_bias_en, // Bias powered
  input wire logic adc_busy // Converting
);
  import iaec_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence vec_s;
    ##1 (!vector_fetch && !global_irq_enabled);
  endsequence
  sequence ctrl_wr_s;
    reg_wr && reg_addr == ADDR_CONV_CTRL;
  endsequence
  vec_addr_a: assert property (vector_addr == VECTOR_ADDR)
    else $error("vector address wrong");
  vec_once_a: assert property (vector_fetch |-> vec_s)
    else $error("vector not single or enable kept");
  gie_on_a: assert property (global_irq_on_instr && !global_irq_off_instr
    |=> global_irq_enabled) else $error("enable not set");
  gie_off_a: assert property (global_irq_off_instr |=> !global_irq_enabled)
    else $error("enable not cleared");
  no_vec_a: assert property (!global_irq_enabled |=> !vector_fetch)
    else $error("vector while disabled");
  rst_pulse_a: assert property ($fell(srst) |-> ##[0:1] core_reset)
    else $error("no reset pulse after release");
  clear_pair_a: assert property (core_reset == wdt_clear)
    else $error("watchdog clear not with reset");
  stop_pair_a: assert property (cpu_stop == osc_stop)
    else $error("core and oscillator stop differ");
  bias_set_a: assert property (ctrl_wr_s |=> ##1
    adc_bias_en == $past(reg_wdata[CC_POWER], 2)) else $error("bias wrong");
  busy_off_a: assert property (!adc_bias_en |=> !adc_busy)
    else $error("busy while powered down");
endmodule : iaec_props
bind iaec_top iaec_props iaec_props_i (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .global_irq_on_instr(global_irq_on_instr),
  .global_irq_off_instr(global_irq_off_instr), .vector_fetch(vector_fetch),
  .vector_addr(vector_addr), .global_irq_enabled(global_irq_enabled),
  .core_reset(core_reset), .wdt_clear(wdt_clear), .cpu_stop(cpu_stop),
  .osc_stop(osc_stop), .adc_bias_en(adc_bias_en), .adc_busy(adc_busy));
`default_nettype wire

// file: testbench/iaec_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module iaec_core_model (
  input wire logic clk, // Clock
  input wire logic vector_fetch, // Vector request
  output logic on_instr, // Enable-interrupt executed
  output logic off_instr, // Disable-interrupt executed
  output logic slp_instr, // Sleep executed
  output var int vec_count // Vectors taken
);
  initial begin
    on_instr = 1'b0;
    off_instr = 1'b0;
    slp_instr = 1'b0;
    vec_count = 0;
  end
  // Counting fetches exposes a double vector for one entry
  always @(posedge clk) begin
    if (vector_fetch === 1'b1) vec_count <= vec_count + 1;
  end
  task exec(input int k);
    @(posedge clk);
    case (k)
      0: on_instr <= 1'b1;
      1: off_instr <= 1'b1;
      default: slp_instr <= 1'b1;
    endcase
    @(posedge clk);
    on_instr <= 1'b0;
    off_instr <= 1'b0;
    slp_instr <= 1'b0;
  endtask : exec
endmodule : iaec_core_model
`default_nettype wire

// file: testbench/iaec_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module iaec_top_tb_top;
  import iaec_pkg::*;
  localparam int DIV = 2;
  logic clk, srst, reg_wr, reg_rd, ext_reset_pin_n, wdt_enable, wdt_timeout;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [5:0] evt;
  logic [3:0] ext_pin;
  logic [9:0] adc_sample_data;
  logic [11:0] vector_addr;
  logic [2:0] adc_channel;
  logic vector_fetch, global_irq_enabled, core_reset, wdt_clear, cpu_stop;
  logic osc_stop, adc_bias_en, adc_busy, on_i, off_i, slp_i;
  int vec_count, bad_count, check_count, n;
  int pin_pos [3];
  int per_pos [3];
  iaec_top #(.ADC_TICK_DIV(DIV)) iaec_top_i (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tcc_timeout(evt[0]),
    .first_counter_irq_enable_timeout(evt[1]), .second_counter_irq_enable_timeout(evt[2]), .pulse1_event(evt[3]),
    .pulse2_event(evt[4]), .serial_rx_full(evt[5]), .ext_pin(ext_pin),
    .ext_reset_pin_n(ext_reset_pin_n), .wdt_enable(wdt_enable),
    .wdt_timeout(wdt_timeout), .global_irq_on_instr(on_i),
    .global_irq_off_instr(off_i), .sleep_instr(slp_i),
    .adc_sample_data(adc_sample_data), .vector_fetch(vector_fetch),
    .vector_addr(vector_addr), .global_irq_enabled(global_irq_enabled),
    .core_reset(core_reset), .wdt_clear(wdt_clear), .cpu_stop(cpu_stop),
    .osc_stop(osc_stop), .adc_bias_en(adc_bias_en),
    .adc_channel(adc_channel), .adc_busy(adc_busy));
  iaec_core_model iaec_core_model_i (.clk(clk), .vector_fetch(vector_fetch),
    .on_instr(on_i), .off_instr(off_i), .slp_instr(slp_i),
    .vec_count(vec_count));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    `CHK(d, e)
  endtask : rc
  task ev(input logic [5:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 6'h00;
  endtask : ev
  // Bounded wait; n ends as the number of edges waited
  task wsig(input logic lvl, input logic which);
    n = 0;
    while (((which ? core_reset : adc_busy) !== lvl) && n < 300) begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wsig
  task conclude;
    if (bad_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    cyc(5000);
    bad_count++;
    conclude();
  end
  initial begin
    {srst, reg_wr, reg_rd, wdt_enable, wdt_timeout} = 5'b10000;
    {reg_addr, reg_wdata, evt} = '0;
    ext_pin = 4'hf;
    ext_reset_pin_n = 1'b1;
    adc_sample_data = 10'h2a5;
    bad_count = 0;
    check_count = 0;
    pin_pos = '{SM_PIN_B, SM_PIN_C, SM_PIN_D};
    per_pos = '{PM_PULSE1, PM_PULSE2, PM_SERIAL_RX};
    cyc(12);
    srst <= 1'b0;
    cyc(2);
    rc(ADDR_PERIPH_MASK, RST_PERIPH_MASK);
    rc(ADDR_SOURCE_MASK, RST_SOURCE_MASK);
    rc(ADDR_CONTROL, 8'hff);
    rc(8'h20, 8'h00);
    wr(ADDR_SOURCE_MASK, 8'h07);
    iaec_core_model_i.exec(0);
    ev(6'h01);
    cyc(4);
    `CHK(vec_count, 1)
    `CHK(global_irq_enabled, 1'b0)
    rc(ADDR_IRQ_STATUS, 8'h01);
    ev(6'h01);
    cyc(4);
    `CHK(vec_count, 1)
    wr(ADDR_IRQ_STATUS, 8'h00);
    rc(ADDR_IRQ_STATUS, 8'h00);
    iaec_core_model_i.exec(0);
    ev(6'h03);
    cyc(4);
    `CHK(vec_count, 2)
    rc(ADDR_IRQ_STATUS, 8'h03);
    wr(ADDR_IRQ_STATUS, 8'h00);
    iaec_core_model_i.exec(0);
    iaec_core_model_i.exec(1);
    ev(6'h04);
    cyc(4);
    `CHK(vec_count, 2)
    wr(ADDR_IRQ_STATUS, 8'h00);
    for (int i = 0; i < 3; i++) begin
      ev(6'h08 << i);
      rc(ADDR_CONV_STATUS, 8'h01 << per_pos[i]);
      wr(ADDR_CONV_STATUS, 8'h00);
    end
    ext_pin[0] <= 1'b0;
    cyc(6);
    rc(ADDR_IRQ_STATUS, 8'h00);
    ext_pin[0] <= 1'b1;
    cyc(6);
    rc(ADDR_IRQ_STATUS, 8'h08);
    wr(ADDR_IRQ_STATUS, 8'h00);
    wr(ADDR_CONTROL, 8'h7f);
    ext_pin[0] <= 1'b0;
    cyc(6);
    rc(ADDR_IRQ_STATUS, 8'h08);
    wr(ADDR_IRQ_STATUS, 8'h00);
    for (int j = 1; j < 4; j++) begin
      ext_pin[j] <= 1'b0;
      cyc(6);
      rc(ADDR_IRQ_STATUS, 8'h01 << pin_pos[j - 1]);
      wr(ADDR_IRQ_STATUS, 8'h00);
      ext_pin[j] <= 1'b1;
      cyc(6);
      rc(ADDR_IRQ_STATUS, 8'h00);
    end
    wr(ADDR_MODE_CTRL, 8'h40);
    wr(ADDR_PERIPH_MASK, 8'h20);
    wr(ADDR_CONV_CTRL, 8'h04);
    wr(ADDR_CONV_CTRL, 8'h05);
    wsig(1'b1, 1'b0);
    wsig(1'b0, 1'b0);
    `CHK(n >= 12 * DIV && n <= 12 * DIV + 1, 1'b1)
    rc(ADDR_CONV_STATUS, 8'h20);
    rc(ADDR_CONV_CTRL, 8'h04);
    rc(ADDR_RESULT_LO, 8'ha5);
    rc(ADDR_RESULT_HI, 8'h02);
    wr(ADDR_MODE_CTRL, 8'h00);
    iaec_core_model_i.exec(0);
    cyc(4);
    `CHK(vec_count, 2)
    wr(ADDR_MODE_CTRL, 8'h40);
    cyc(4);
    `CHK(vec_count, 3)
    rc(ADDR_CONV_STATUS, 8'h20);
    wr(ADDR_CONV_STATUS, 8'h00);
    wr(ADDR_PERIPH_MASK, 8'h00);
    adc_sample_data <= 10'h15a;
    // Channel 5 and converter clock halved, still free-running
    wr(ADDR_CONV_CTRL, 8'had);
    cyc(80);
    rc(ADDR_CONV_CTRL, 8'had);
    `CHK(adc_channel, 3'h5)
    rc(ADDR_CONV_STATUS, 8'h00);
    `CHK(adc_busy, 1'b1)
    wr(ADDR_PERIPH_MASK, 8'h20);
    wsig(1'b0, 1'b0);
    rc(ADDR_CONV_STATUS, 8'h20);
    rc(ADDR_RESULT_LO, 8'h5a);
    rc(ADDR_RESULT_HI, 8'h01);
    wr(ADDR_CONV_CTRL, 8'h00);
    cyc(3);
    `CHK(adc_bias_en, 1'b0)
    wr(ADDR_STATUS_REG, 8'hff);
    wr(ADDR_REG_SELECT, 8'hff);
    wr(ADDR_MODE_CTRL, 8'h00);
    iaec_core_model_i.exec(2);
    cyc(2);
    `CHK(cpu_stop, 1'b1)
    wdt_enable <= 1'b1;
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    // The wake pulse lasts one cycle, so look right after its edge
    #1 `CHK(core_reset, 1'b1)
    cyc(2);
    `CHK(cpu_stop, 1'b0)
    rc(ADDR_STATUS_REG, 8'h1f);
    rc(ADDR_REG_SELECT, 8'h3f);
    wdt_enable <= 1'b0;
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    #1 `CHK(core_reset, 1'b0)
    wr(ADDR_SOURCE_MASK, 8'h15);
    wr(ADDR_STATUS_REG, 8'hff);
    ext_reset_pin_n <= 1'b0;
    wsig(1'b1, 1'b1);
    `CHK(n >= 2 && n <= 4, 1'b1)
    ext_reset_pin_n <= 1'b1;
    cyc(6);
    rc(ADDR_SOURCE_MASK, 8'h00);
    rc(ADDR_CONTROL, 8'hff);
    rc(ADDR_STATUS_REG, 8'hff);
    conclude();
  end
endmodule : iaec_top_tb_top
`default_nettype wire
